// file: rtl/ltct_top.sv
// Lite timebase and capture timer: two counters, capture and APB slave.
//
// Behaviour
// R1: Software writes zeros to reserved bits 7:2 of the timebase-2 register.
// R2: Timebase-2 bit 1 enables the counter-2 overflow interrupt request.
// R3: Timebase-2 bit 0 set on counter-2 overflow, cleared by reading it.
// R4: Reload register is read/write and reloads counter 2 on overflow.
// R5: Counter-2 readback is read-only, resets to zero, writes ignored.
// R6: Timebase-1/capture register resets to zero except the capture flag.
// R7: Timebase-1/capture bit 7 enables the capture interrupt request.
// R8: Capture flag set on capture, cleared only by reading capture value.
// R9: Software reads the capture register once after every reset.
// R10: Bit 5 selects timebase-1 period of 8000 or 16000 oscillator periods.
// R11: Bit 4 enables the counter-1 overflow interrupt request.
// R12: Bit 3 set on counter-1 overflow, cleared by reading its register.
// R13: Capture value resets to zero, latches counter 1 on any pin edge; the code ignores edges while the capture flag is set.
// R14: Registers sit at indices 08, 09, 0A, 0B and 0C in that order.
// R15: Counter 1 counts at oscillator/32 and overflows wrapping F9h to 00h.
// R16: Counter 2 counts at oscillator/32, reloading after it passes FFh.
// R17: Both counters stop in full halt and run in all other modes.
// R18: A set in the same cycle as its clearing read wins; the code drops a capture edge that arrives as the capture flag clears.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ltct_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_input_pin,
    input wire logic full_halt,
    output logic irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic tick;
    logic cap_edge;
    logic [7:0] first_counter;
    logic long_half;
    logic [7:0] second_counter_bits;
    logic [7:0] reload_value_bits;
    logic [7:0] captured_count_bits;
    logic second_timebase_irq_enable;
    logic second_timebase_overflow_flag;
    logic capture_irq_enable;
    logic capture_flag;
    logic period_select;
    logic first_timebase_irq_enable;
    logic first_timebase_overflow_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic snap_first_timebase_overflow_flag;
    logic snap_second_timebase_overflow_flag;
    logic snap_capf;

    // ----------------------------------------------------------------
    // Time base and capture pin
    // ----------------------------------------------------------------
    // One shared prescaler keeps both counters in step at osc/32.
    ltct_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .halt(full_halt),
        .tick(tick)
    );

    ltct_edge_detect u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(capture_input_pin),
        .edge_seen(cap_edge)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // The access phase takes two cycles: data is sampled in the first,
    // pready rises in the second, and side effects land on that edge.
    wire access = psel && penable;
    wire done = access && pready;
    wire rd_done = done && !pwrite;
    wire wr_done = done && pwrite;
    wire hit_tb2 = ltct_pkg::reg_hit(paddr, ltct_pkg::IDX_TB2_CSR);
    wire hit_reload = ltct_pkg::reg_hit(paddr, ltct_pkg::IDX_RELOAD);
    wire hit_cnt2 = ltct_pkg::reg_hit(paddr, ltct_pkg::IDX_CNT2);
    wire hit_tb1 = ltct_pkg::reg_hit(paddr, ltct_pkg::IDX_TB1_CSR);
    wire hit_capv = ltct_pkg::reg_hit(paddr, ltct_pkg::IDX_CAPV);
    wire hit_stat = ltct_pkg::reg_hit(paddr, ltct_pkg::IDX_IRQ_STATUS);
    wire hit_mask = ltct_pkg::reg_hit(paddr, ltct_pkg::IDX_IRQ_MASK);
    wire mapped = hit_tb2 || hit_reload || hit_cnt2 || hit_tb1
        || hit_capv || hit_stat || hit_mask;

    // Status layouts assembled once for reads.
    wire [7:0] tb2_view = {6'h00, second_timebase_irq_enable,
        second_timebase_overflow_flag};
    wire [7:0] tb1_view = {capture_irq_enable, capture_flag,
        period_select, first_timebase_irq_enable,
        first_timebase_overflow_flag, 3'h0};

    // Read selection; unmapped addresses read zero.
    wire [7:0] rd_val =
        hit_tb2 ? tb2_view :
        hit_reload ? reload_value_bits :
        hit_cnt2 ? second_counter_bits :
        hit_tb1 ? tb1_view :
        hit_capv ? captured_count_bits :
        hit_stat ? {5'h00, irq_status} :
        hit_mask ? {5'h00, irq_mask} : 8'h00;

    // ----------------------------------------------------------------
    // Counter events
    // ----------------------------------------------------------------
    // Counter 1 runs 0..F9h, 250 ticks of 32 periods; the long period
    // counts two wraps before one event.
    wire c1_wrap = tick && (first_counter == ltct_pkg::C1_LAST); // R15
    wire tb1_evt = c1_wrap
        && (!period_select || (long_half == ltct_pkg::LONG_LAST)); // R10
    wire tb2_evt = tick
        && (second_counter_bits == ltct_pkg::C2_LAST); // R16
    wire cap_evt = cap_edge && !capture_flag; // R13

    // Flags clear only when the value the reader saw held them set.
    // This closes the gap between sampling and the clearing edge.
    wire clr_second_timebase_overflow_flag = rd_done && hit_tb2 && snap_second_timebase_overflow_flag; // R3
    wire clr_first_timebase_overflow_flag = rd_done && hit_tb1 && snap_first_timebase_overflow_flag; // R12
    wire clr_capf = rd_done && hit_capv && snap_capf; // R8

    // Set beats clear for both overflow flags; a capture edge in the capture flag's clearing cycle is dropped.
    wire next_second_timebase_overflow_flag = tb2_evt
        || (second_timebase_overflow_flag && !clr_second_timebase_overflow_flag); // R18
    wire next_first_timebase_overflow_flag = tb1_evt
        || (first_timebase_overflow_flag && !clr_first_timebase_overflow_flag); // R18
    wire next_capf = cap_evt || (capture_flag && !clr_capf); // R18

    // Interrupt status: events set, writing one clears, set wins.
    wire [2:0] evt_vec = {cap_evt, tb2_evt, tb1_evt};
    wire [2:0] w1c = (wr_done && hit_stat) ? pwdata[2:0] : 3'h0;
    wire [2:0] next_irq_status = evt_vec | (irq_status & ~w1c);
    wire [2:0] enable_vec = {capture_irq_enable,
        second_timebase_irq_enable, first_timebase_irq_enable};

    // ----------------------------------------------------------------
    // Counter 1
    // ----------------------------------------------------------------
    // Not visible to software; only feeds overflow and capture.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_counter <= ltct_pkg::CNT_RST;
            long_half <= 1'b0;
        end else if (c1_wrap) begin
            first_counter <= 8'h00; // R15
            long_half <= !long_half;
        end else if (tick) begin
            first_counter <= first_counter + 8'h01; // R17
        end
    end

    // ----------------------------------------------------------------
    // Counter 2
    // ----------------------------------------------------------------
    // A reload written mid-period takes effect at the next overflow.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_counter_bits <= ltct_pkg::CNT_RST; // R5
        end else if (tb2_evt) begin
            second_counter_bits <= reload_value_bits; // R4
        end else if (tick) begin
            second_counter_bits <= second_counter_bits + 8'h01; // R17
        end
    end

    // ----------------------------------------------------------------
    // Software-written control
    // ----------------------------------------------------------------
    // Flag bits, reserved bits and read-only registers ignore writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_value_bits <= ltct_pkg::RELOAD_RST;
            second_timebase_irq_enable <= 1'b0;
            capture_irq_enable <= 1'b0; // R6
            period_select <= 1'b0;
            first_timebase_irq_enable <= 1'b0;
            irq_mask <= ltct_pkg::IRQ_RST;
        end else if (wr_done) begin
            if (hit_reload) begin
                reload_value_bits <= pwdata[7:0]; // R4
            end
            if (hit_tb2) begin
                second_timebase_irq_enable <=
                    pwdata[ltct_pkg::SECOND_TIMEBASE_IRQ_ENABLE_BIT]; // R2
            end
            if (hit_tb1) begin
                capture_irq_enable <= pwdata[ltct_pkg::CAPIE_BIT]; // R7
                period_select <= pwdata[ltct_pkg::PERIOD_SEL_BIT]; // R10
                first_timebase_irq_enable <=
                    pwdata[ltct_pkg::FIRST_TIMEBASE_IRQ_ENABLE_BIT]; // R11
            end
            if (hit_mask) begin
                irq_mask <= pwdata[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Flags and capture
    // ----------------------------------------------------------------
    // The capture flag comes out of reset clear; software still reads
    // the capture value once to stay safe on any build.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_timebase_overflow_flag <= 1'b0;
            first_timebase_overflow_flag <= 1'b0; // R6
            capture_flag <= 1'b0;
            captured_count_bits <= ltct_pkg::CAPV_RST; // R13
            irq_status <= ltct_pkg::IRQ_RST;
        end else begin
            second_timebase_overflow_flag <= next_second_timebase_overflow_flag; // R3
            first_timebase_overflow_flag <= next_first_timebase_overflow_flag; // R12
            capture_flag <= next_capf; // R8
            irq_status <= next_irq_status;
            if (cap_evt) begin
                captured_count_bits <= first_counter; // R13
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    // Data and flag snapshots are taken in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            snap_first_timebase_overflow_flag <= 1'b0;
            snap_second_timebase_overflow_flag <= 1'b0;
            snap_capf <= 1'b0;
        end else begin
            pready <= access && !pready;
            if (access && !pready) begin
                prdata <= {24'h00_0000, rd_val}; // R14
                pslverr <= !mapped;
                snap_first_timebase_overflow_flag <= first_timebase_overflow_flag;
                snap_second_timebase_overflow_flag <= second_timebase_overflow_flag;
                snap_capf <= capture_flag;
            end else if (!access) begin
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------
    // A source needs both its own enable bit and its mask bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask & enable_vec); // R2
        end
    end

endmodule
`default_nettype wire

// file: rtl/ltct_pkg.sv
// Shared constants and helpers of the lite timebase and capture timer.
package ltct_pkg;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_TB2_CSR = 6'h08;
    localparam logic [5:0] IDX_RELOAD = 6'h09;
    localparam logic [5:0] IDX_CNT2 = 6'h0A;
    localparam logic [5:0] IDX_TB1_CSR = 6'h0B;
    localparam logic [5:0] IDX_CAPV = 6'h0C;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h11;

    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int SECOND_TIMEBASE_OVERFLOW_FLAG_BIT = 0;
    localparam int SECOND_TIMEBASE_IRQ_ENABLE_BIT = 1;
    localparam int FIRST_TIMEBASE_OVERFLOW_FLAG_BIT = 3;
    localparam int FIRST_TIMEBASE_IRQ_ENABLE_BIT = 4;
    localparam int PERIOD_SEL_BIT = 5;
    localparam int CAPF_BIT = 6;
    localparam int CAPIE_BIT = 7;
    localparam int IRQ_TB1_BIT = 0;
    localparam int IRQ_TB2_BIT = 1;
    localparam int IRQ_CAP_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values.
    // ----------------------------------------------------------------
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CAPV_RST = 8'h00;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // ----------------------------------------------------------------
    // Timing, in oscillator (pclk) periods.
    // ----------------------------------------------------------------
    localparam int PRESCALE_DIV = 32;
    localparam int SHORT_PERIOD_OSC = 8000;
    localparam int LONG_PERIOD_OSC = 16000;
    localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE_DIV - 1);
    localparam logic [7:0] C1_LAST =
        8'(SHORT_PERIOD_OSC / PRESCALE_DIV - 1);
    localparam logic LONG_LAST = 1'(LONG_PERIOD_OSC / SHORT_PERIOD_OSC - 1);
    localparam logic [7:0] C2_LAST = 8'hFF;

    // True when an aligned byte address selects the given register index.
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [5:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction

endpackage

// file: rtl/ltct_prescaler.sv
// Divide-by-32 tick generator that freezes during full halt.
`timescale 1ns/10ps
`default_nettype none
module ltct_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic halt,
    output logic tick
);

    logic [4:0] count;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // The count holds its place in halt, so a period resumes where it
    // stopped instead of restarting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 5'h00;
            tick <= 1'b0;
        end else begin
            tick <= !halt && (count == ltct_pkg::PRESCALE_LAST);
            if (!halt) begin
                count <= count + 5'h01;
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/ltct_edge_detect.sv
// Detector of rising and falling edges on the capture pin.
`timescale 1ns/10ps
`default_nettype none
module ltct_edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic edge_seen
);

    logic last;
    logic primed;

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    // The primed bit keeps a pin that is already high at reset release
    // from looking like an edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 1'b0;
            primed <= 1'b0;
        end else begin
            last <= pin;
            primed <= 1'b1;
        end
    end

    assign edge_seen = primed && (pin != last);

endmodule
`default_nettype wire

// file: testbench/ltct_monitor.sv
// Port-level assertions of the lite timebase and capture timer.
`timescale 1ns/10ps
`default_nettype none
module ltct_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic capture_input_pin,
    input wire logic full_halt,
    input wire logic irq
);
    // ----------------------------------------------------------------
    // Decode and clocking
    // ----------------------------------------------------------------
    // Seven aligned words answer; a stray or unaligned address must not.
    logic mapped;
    assign mapped = paddr inside {8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
                                  8'h40, 8'h44};
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    a_one_wait: assert property (
        $rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_in_xfer: assert property (
        pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_decode: assert property (
        pready |-> pslverr == !mapped)
        else $error("error response does not match the address");
    a_upper_zero: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data above bit 7 not zero");
    a_rdata_hold: assert property (
        !(psel && penable && !pready) |=> $stable(prdata))
        else $error("read data moved outside an access");
    a_reserved_zero: assert property (
        pready && !pwrite && paddr == 8'h20 |-> prdata[7:2] == 6'h00)
        else $error("reserved timebase-2 bits read nonzero");
    a_reset_quiet: assert property (
        !$past(presetn) |-> !pready && !irq && !pslverr)
        else $error("outputs active just after reset");
endmodule

bind ltct_top ltct_monitor ltct_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .full_halt(full_halt),
    .capture_input_pin(capture_input_pin), .irq(irq)
);
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench of the lite timebase and capture timer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, capture_input_pin = 1'b0, full_halt = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, rd_err;
    int num_errors = 0, comparisons = 0, cyc = 0;
    int mapped[$] = '{32'h20, 32'h24, 32'h28, 32'h2C, 32'h30, 32'h40, 32'h44};
    // Model of the capture register: counter-1 ticks expected per capture.
    int cap_q[$];

    ltct_top ltct_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .full_halt(full_halt),
        .capture_input_pin(capture_input_pin), .irq(irq)
    );
    // ----------------------------------------------------------------
    // Clock, cycle count and helpers
    // ----------------------------------------------------------------
    // Event times are taken from this count, so periods are exact.
    always #10 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s: %h not %h", $time, what, got, exp);
        end
    endtask

    task automatic check_irq(input logic exp);
        comparisons++;
        if (irq !== exp) begin
            num_errors++;
            $display("BAD %0t irq level %b", $time, irq);
        end
    endtask

    task automatic give_up(input string what);
        num_errors++;
        $display("BAD %0t wait ran out: %s", $time, what);
        complete_run();
    endtask

    // One transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) give_up("bus answer");
    endtask

    task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp,
                             input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        check(rd & m, exp, "read data");
        check(32'(rd_err), 32'(!(int'(a) inside {mapped})), "response");
    endtask

    // The irq flop lags its status by a cycle, so skip two edges first.
    task automatic wait_irq(input int limit, output int t);
        int n;
        n = 0;
        repeat (2) @(posedge pclk);
        while (irq !== 1'b1 && n < limit) begin
            @(posedge pclk);
            n++;
        end
        t = cyc;
        if (n >= limit) give_up("interrupt");
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int t1, t2, n, h;
        logic [7:0] rl;
        void'($urandom(32'hED0FF6AE));
        rl = 8'($urandom_range(8'hFE, 8'hF0));
        n = $urandom_range(3'h7, 3'h1);
        h = $urandom_range(8'h96, 8'h32);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (mapped[i]) begin
            expect_rd(8'(mapped[i]), 32'h0, 32'hFF);
        end
        expect_rd(8'h34, 32'h0, 32'hFFFFFFFF);
        expect_rd(8'h21, 32'h0, 32'hFFFFFFFF);
        $display("test reset done");
        apb(1'b1, 8'h28, 32'hFFFFFFFF);
        apb(1'b1, 8'h30, 32'hFFFFFFFF);
        apb(1'b1, 8'h24, {24'h0, rl});
        apb(1'b1, 8'h20, 32'h2);
        apb(1'b1, 8'h2C, 32'hDF);
        expect_rd(8'h24, {24'h0, rl}, 32'hFF);
        expect_rd(8'h20, 32'h2, 32'hFF);
        expect_rd(8'h2C, 32'h90, 32'hFF);
        expect_rd(8'h30, 32'h0, 32'hFF);
        expect_rd(8'h28, 32'h0, 32'hF0);
        $display("test access done");
        apb(1'b1, 8'h44, 32'h1);
        wait_irq(9000, t1);
        while (cyc < t1 + ltct_pkg::PRESCALE_DIV * n) begin
            @(posedge pclk);
        end
        capture_input_pin <= ~capture_input_pin;
        cap_q.push_back(n);
        expect_rd(8'h2C, 32'hD8, 32'hFF);
        expect_rd(8'h2C, 32'hD0, 32'hFF);
        capture_input_pin <= ~capture_input_pin;
        expect_rd(8'h30, 32'(cap_q.pop_front()), 32'hFF);
        expect_rd(8'h2C, 32'h90, 32'hFF);
        apb(1'b1, 8'h2C, 32'hD8);
        expect_rd(8'h2C, 32'h90, 32'hFF);
        expect_rd(8'h40, 32'h5, 32'h5);
        apb(1'b1, 8'h40, 32'h1);
        apb(1'b1, 8'h44, 32'h4);
        expect_rd(8'h44, 32'h4, 32'h7);
        check_irq(1'b1);
        apb(1'b1, 8'h40, 32'h4);
        expect_rd(8'h40, 32'h0, 32'h5);
        check_irq(1'b0);
        apb(1'b1, 8'h44, 32'h1);
        wait_irq(9000, t2);
        check(32'(t2 - t1), ltct_pkg::SHORT_PERIOD_OSC, "short");
        apb(1'b1, 8'h2C, 32'hB0);
        apb(1'b1, 8'h40, 32'h1);
        wait_irq(17000, t1);
        apb(1'b1, 8'h40, 32'h1);
        wait_irq(17000, t2);
        check(32'(t2 - t1), ltct_pkg::LONG_PERIOD_OSC, "long");
        $display("test timebase one done");
        apb(1'b1, 8'h44, 32'h2);
        wait_irq(9000, t1);
        apb(1'b1, 8'h40, 32'h2);
        expect_rd(8'h20, 32'h2, 32'hFE);
        wait_irq(9000, t1);
        expect_rd(8'h20, 32'h3, 32'hFF);
        expect_rd(8'h20, 32'h2, 32'hFF);
        expect_rd(8'h28, {24'h0, rl}, 32'hFF);
        apb(1'b1, 8'h40, 32'h2);
        full_halt <= 1'b1;
        repeat (h) @(posedge pclk);
        full_halt <= 1'b0;
        wait_irq(9000, t2);
        check(32'(t2 - t1), 32'((32'h100 - rl) * 32'h20 + h), "reload");
        apb(1'b1, 8'h44, 32'h0);
        expect_rd(8'h44, 32'h0, 32'h7);
        check_irq(1'b0);
        $display("test timebase two done");
        complete_run();
    end
endmodule
`default_nettype wire
